//--- mad_addr_calc.sv
`timescale 1ns/1ps
// combinational address former
module mad_addr_calc
    import mad_pkg::*;
#(
    parameter int ONCHIP_EXTERNAL_RAM_AW = 9
)
(
    input wire mad_mode_e i_mode,
    input wire logic [15:0] i_addr,
    input wire logic i_ptr_sel,
    input wire logic [7:0] i_r0,
    input wire logic [7:0] i_r1,
    input wire logic [7:0] i_sp,
    input wire logic [15:0] i_data_pointer_16,
    input wire logic [7:0] i_page,
    output logic [7:0] o_iram_addr,
    output logic [2:0] o_bit_pos,
    output logic o_bit_in_ram,
    output logic [ONCHIP_EXTERNAL_RAM_AW-1:0] o_onchip_external_ram_addr
);
    wire [7:0] ptr = i_ptr_sel ? i_r1 : i_r0;
    wire [7:0] bit_byte = BIT_AREA_BASE + {4'h0, i_addr[6:3]};
    wire [7:0] sfr_bit_byte = {i_addr[7:3], SFR_BIT_LOW_NIBBLE};
    wire [15:0] x8 = {i_page, ptr};
    wire [7:0] sp_inc = i_sp + 8'h01;
    assign o_bit_pos = i_addr[2:0];
    assign o_bit_in_ram = (i_addr[7] == 1'b0);
    always_comb
    begin
        o_iram_addr = i_addr[7:0];
        case (i_mode)
            MAD_INDIRECT: o_iram_addr = ptr;
            MAD_BIT: o_iram_addr = i_addr[7] ? sfr_bit_byte : bit_byte;
            MAD_PUSH: o_iram_addr = sp_inc;
            MAD_POP: o_iram_addr = i_sp;
            default: o_iram_addr = i_addr[7:0];
        endcase
    end
    // upper bits dropped: fold onto implemented ram
    assign o_onchip_external_ram_addr = (i_mode == MAD_XDATA8) ? x8[ONCHIP_EXTERNAL_RAM_AW-1:0]
        : i_data_pointer_16[ONCHIP_EXTERNAL_RAM_AW-1:0];
endmodule

//--- mad_core_model.sv
`timescale 1ns/1ps
// core side: issues one access per call, then scrambles released fields
module mad_core_model
    import mad_pkg::*;
(
    input wire logic i_sys_clk,
    output logic o_req,
    output mad_mode_e o_mode,
    output logic o_write,
    output logic [15:0] o_addr,
    output logic o_ptr_sel,
    output logic [7:0] o_wdata,
    output logic o_redirect
);
    initial
    begin
        o_req = 1'b0;
        o_mode = MAD_DIRECT;
        o_write = 1'b0;
        o_addr = 16'h0000;
        o_ptr_sel = 1'b0;
        o_wdata = 8'h00;
        o_redirect = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // gap gives a slow core some idle cycles first
    task automatic issue(input mad_mode_e mode, input logic wr,
        input logic [15:0] addr, input logic ptr, input logic [7:0] wd,
        input logic redir, input int gap);
        repeat (gap) @(posedge i_sys_clk);
        @(posedge i_sys_clk);
        o_req <= 1'b1;
        o_mode <= mode;
        o_write <= wr;
        o_addr <= addr;
        o_ptr_sel <= ptr;
        o_wdata <= wd;
        o_redirect <= redir;
        @(posedge i_sys_clk);
        o_req <= 1'b0;
        o_addr <= ~addr;
        o_wdata <= ~wd;
        o_write <= ~wr;
    endtask
endmodule

//--- mad_decoder.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - flash spans 0x0000 to 0x3BFF or 0x1FFF; above that reserved.
// - code reads go to flash; xdata writes may go to flash.
// - without redirection, xdata accesses hit on-chip external ram.
// - 768 bytes data ram: 256 internal, rest external.
// - lower 128 bytes reachable directly and indirectly.
// - 0x00-0x1F are four register banks, chosen by status bits 3,4.
// - direct access above 0x7F goes to sfr space.
// - indirect access above 0x7F goes to upper internal ram.
// - indirect pointer is r0 or r1 of active bank.
// - bytes 0x20-0x2F are 128 bits, address 8*offset plus bit.
// - bit or byte access follows the operand type.
// - stack pointer marks last entry; push writes sp+1 then increments.
// - reset loads stack pointer with 0x07.
// - stack lives anywhere in 256 internal bytes, depth 256.
// - 512 bytes external ram via data pointer or register pointer.
// - 16-bit xdata uses data pointer; high and low bytes accessible.
// - 8-bit xdata address is page register high, r0/r1 low.
// - external ram needs no setup before use.
// - sfrs at addresses ending 0 or 8 are bit-addressable.
module mad_decoder
    import mad_pkg::*;
#(
    parameter logic FLASH_16K = 1'b1,
    parameter int ONCHIP_EXTERNAL_RAM_AW = 9
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire mad_mode_e i_mode,
    input wire logic i_write,
    input wire logic [15:0] i_addr,
    input wire logic i_ptr_sel,
    input wire logic [7:0] i_wdata,
    input wire logic i_flash_wr_redirect,
    output logic o_valid,
    output mad_target_e o_target,
    output logic [7:0] o_iram_addr,
    output logic [ONCHIP_EXTERNAL_RAM_AW-1:0] o_onchip_external_ram_addr,
    output logic [15:0] o_code_addr,
    output logic [7:0] o_sfr_addr,
    output logic o_bit_access,
    output logic [2:0] o_bit_pos,
    output logic o_write,
    output logic [7:0] o_wdata,
    output logic o_reserved,
    output logic o_bad_bit,
    output logic [7:0] o_stack_pointer,
    output logic [15:0] o_data_pointer_16,
    output logic [7:0] o_onchip_external_ram_upper_address_page,
    output logic [1:0] o_active_bank
);
    ////////////////////////////////////////////////////////////////////////////
    // architectural registers
    logic [7:0] stack_pointer_reg;
    logic [7:0] stack_pointer_next;
    logic [7:0] data_pointer_low_reg;
    logic [7:0] data_pointer_high_reg;
    logic [7:0] onchip_external_ram_upper_address_page_reg;
    logic [7:0] program_status_word_reg;
    // shadow of r0/r1 for each bank
    logic [7:0] r0_reg [4];
    logic [7:0] r1_reg [4];

    wire [1:0] bank = {program_status_word_reg[BANK_SELECT_HIGH_POS],
        program_status_word_reg[BANK_SELECT_LOW_POS]};
    wire [15:0] data_pointer_16 = {data_pointer_high_reg, data_pointer_low_reg};
    wire [7:0] cur_r0 = r0_reg[bank];
    wire [7:0] cur_r1 = r1_reg[bank];

    ////////////////////////////////////////////////////////////////////////////
    // address forming
    wire [7:0] iram_addr;
    wire [2:0] bit_pos;
    wire bit_in_ram;
    wire [ONCHIP_EXTERNAL_RAM_AW-1:0] onchip_external_ram_addr;

    mad_addr_calc #(
        .ONCHIP_EXTERNAL_RAM_AW(ONCHIP_EXTERNAL_RAM_AW)
    ) u_calc (
        .i_mode(i_mode),
        .i_addr(i_addr),
        .i_ptr_sel(i_ptr_sel),
        .i_r0(cur_r0),
        .i_r1(cur_r1),
        .i_sp(stack_pointer_reg),
        .i_data_pointer_16(data_pointer_16),
        .i_page(onchip_external_ram_upper_address_page_reg),
        .o_iram_addr(iram_addr),
        .o_bit_pos(bit_pos),
        .o_bit_in_ram(bit_in_ram),
        .o_onchip_external_ram_addr(onchip_external_ram_addr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // target selection
    wire [15:0] flash_last = FLASH_16K ? FLASH_LAST_16K : FLASH_LAST_8K;
    wire is_direct = (i_mode == MAD_DIRECT);
    wire is_bit = (i_mode == MAD_BIT);
    wire is_xdata = (i_mode == MAD_XDATA16) || (i_mode == MAD_XDATA8);
    wire direct_sfr = is_direct && (i_addr[7:0] > LOWER_RAM_TOP);
    wire bit_sfr = is_bit && !bit_in_ram;
    wire code_reserved = (i_mode == MAD_CODE) && (i_addr > flash_last);
    wire xdata_flash = is_xdata && i_write && i_flash_wr_redirect;
    wire sfr_hit = direct_sfr || bit_sfr;
    wire [7:0] sfr_addr = is_bit ? iram_addr : i_addr[7:0];
    wire sfr_wr = i_req && i_write && sfr_hit && !is_bit;
    wire push = i_req && (i_mode == MAD_PUSH);
    wire pop = i_req && (i_mode == MAD_POP);
    wire ram_wr_r0 = i_req && i_write && !sfr_hit && !is_xdata
        && (i_mode != MAD_CODE) && !is_bit && (iram_addr < BIT_AREA_BASE)
        && (iram_addr[2:0] == 3'h0);
    wire ram_wr_r1 = i_req && i_write && !sfr_hit && !is_xdata
        && (i_mode != MAD_CODE) && !is_bit && (iram_addr < BIT_AREA_BASE)
        && (iram_addr[2:0] == 3'h1);
    wire push_wr_r0 = push && (iram_addr < BIT_AREA_BASE)
        && (iram_addr[2:0] == 3'h0);
    wire push_wr_r1 = push && (iram_addr < BIT_AREA_BASE)
        && (iram_addr[2:0] == 3'h1);

    mad_target_e target_next;
    always_comb
    begin
        case (i_mode)
            MAD_CODE: target_next = code_reserved ? MAD_T_NONE
                : MAD_T_FLASH;
            MAD_XDATA16, MAD_XDATA8: target_next = xdata_flash
                ? MAD_T_FLASH_WR : MAD_T_ONCHIP_EXTERNAL_RAM;
            MAD_DIRECT: target_next = direct_sfr ? MAD_T_SFR
                : MAD_T_IRAM;
            MAD_BIT: target_next = bit_sfr ? MAD_T_SFR : MAD_T_IRAM;
            MAD_INDIRECT: target_next = MAD_T_IRAM;
            MAD_PUSH, MAD_POP: target_next = MAD_T_IRAM;
            default: target_next = MAD_T_NONE;
        endcase
    end

    // stack pointer: push pre-increments, pop post-decrements; 8 bits wrap
    always_comb
    begin
        stack_pointer_next = stack_pointer_reg;
        if (push)
            stack_pointer_next = stack_pointer_reg + 8'h01;
        else if (pop)
            stack_pointer_next = stack_pointer_reg - 8'h01;
        else if (sfr_wr && i_addr[7:0] == SFR_STACK_POINTER)
            stack_pointer_next = i_wdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            stack_pointer_reg <= STACK_POINTER_RST;
        else
            stack_pointer_reg <= stack_pointer_next;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            data_pointer_low_reg <= DATA_POINTER_16_BYTE_RST;
            data_pointer_high_reg <= DATA_POINTER_16_BYTE_RST;
        end
        else if (sfr_wr && i_addr[7:0] == SFR_DATA_POINTER_LOW)
            data_pointer_low_reg <= i_wdata;
        else if (sfr_wr && i_addr[7:0] == SFR_DATA_POINTER_HIGH)
            data_pointer_high_reg <= i_wdata;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            onchip_external_ram_upper_address_page_reg <= ONCHIP_EXTERNAL_RAM_PAGE_RST;
            program_status_word_reg <= PSW_RST;
        end
        else if (sfr_wr && i_addr[7:0] == SFR_ONCHIP_EXTERNAL_RAM_UPPER_ADDRESS_PAGE)
            onchip_external_ram_upper_address_page_reg <= i_wdata;
        else if (sfr_wr && i_addr[7:0] == SFR_PROGRAM_STATUS_WORD)
            program_status_word_reg <= i_wdata;
    end

    // r0/r1 shadows track writes to bank locations
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_bank
            wire hit = (iram_addr[4:3] == 2'(gb));
            wire [7:0] wv = push ? i_wdata : i_wdata;
            always_ff @(posedge i_sys_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    r0_reg[gb] <= 8'h00;
                    r1_reg[gb] <= 8'h00;
                end
                else if (hit && (ram_wr_r0 || push_wr_r0))
                    r0_reg[gb] <= wv;
                else if (hit && (ram_wr_r1 || push_wr_r1))
                    r1_reg[gb] <= wv;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_valid <= 1'b0;
            o_target <= MAD_T_NONE;
            o_iram_addr <= 8'h00;
            o_onchip_external_ram_addr <= '0;
            o_code_addr <= 16'h0000;
            o_sfr_addr <= 8'h00;
            o_bit_access <= 1'b0;
            o_bit_pos <= 3'h0;
            o_write <= 1'b0;
            o_wdata <= 8'h00;
            o_reserved <= 1'b0;
            o_bad_bit <= 1'b0;
        end
        else
        begin
            o_valid <= i_req;
            o_target <= i_req ? target_next : MAD_T_NONE;
            o_iram_addr <= iram_addr;
            o_onchip_external_ram_addr <= onchip_external_ram_addr;
            o_code_addr <= i_addr;
            o_sfr_addr <= sfr_addr;
            o_bit_access <= i_req && is_bit;
            o_bit_pos <= bit_pos;
            o_write <= i_req && (i_write || (i_mode == MAD_PUSH));
            o_wdata <= i_wdata;
            o_reserved <= i_req && code_reserved;
            o_bad_bit <= i_req && bit_sfr
                && (sfr_addr[2:0] != SFR_BIT_LOW_NIBBLE);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_stack_pointer <= STACK_POINTER_RST;
            o_data_pointer_16 <= {DATA_POINTER_16_BYTE_RST, DATA_POINTER_16_BYTE_RST};
            o_onchip_external_ram_upper_address_page <= ONCHIP_EXTERNAL_RAM_PAGE_RST;
            o_active_bank <= 2'h0;
        end
        else
        begin
            o_stack_pointer <= stack_pointer_reg;
            o_data_pointer_16 <= data_pointer_16;
            o_onchip_external_ram_upper_address_page <= onchip_external_ram_upper_address_page_reg;
            o_active_bank <= bank;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // reference values, taken in the cycle of the request
    wire [7:0] ptr_now = i_ptr_sel ? cur_r1 : cur_r0;
    wire [7:0] bit_byte_now = BIT_AREA_BASE + {4'h0, i_addr[6:3]};
    wire [15:0] x8_full = {onchip_external_ram_upper_address_page_reg, ptr_now};
    wire [ONCHIP_EXTERNAL_RAM_AW-1:0] x8_now = x8_full[ONCHIP_EXTERNAL_RAM_AW-1:0];
    wire [ONCHIP_EXTERNAL_RAM_AW-1:0] data_pointer_16_now = data_pointer_16[ONCHIP_EXTERNAL_RAM_AW-1:0];
    wire bit_req = i_req && is_bit;

    AST_DIRECT_SFR: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        i_req && is_direct && i_addr[7] |=> o_target == MAD_T_SFR)
        else $error("direct high address not routed to sfr");
    AST_INDIRECT_IRAM: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) i_req && i_mode == MAD_INDIRECT
        |=> o_target == MAD_T_IRAM)
        else $error("indirect access not routed to ram");
    AST_PTR_SEL: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) i_req && i_mode == MAD_INDIRECT
        |=> o_iram_addr == $past(ptr_now))
        else $error("indirect pointer wrong");
    AST_PUSH_ADDR: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        push |=> o_iram_addr == stack_pointer_reg)
        else $error("push address not new stack pointer");
    AST_POP_ADDR: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        pop |=> o_iram_addr == $past(stack_pointer_reg))
        else $error("pop address not old stack pointer");
    AST_SP_POP: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        pop |=> stack_pointer_reg == $past(stack_pointer_reg) - 8'h01)
        else $error("pop did not step stack pointer down");
    AST_SP_RESET: assert property (@(posedge i_sys_clk)
        $fell(i_rst) |-> stack_pointer_reg == STACK_POINTER_RST)
        else $error("stack pointer reset value wrong");
    AST_BIT_MAP: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) bit_req && !i_addr[7]
        |=> o_iram_addr == $past(bit_byte_now))
        else $error("bit address mapping wrong");
    AST_BIT_FLAG: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        o_valid |-> o_bit_access == $past(bit_req))
        else $error("bit access flag wrong");
    AST_SFR_BIT: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) i_req && bit_sfr
        |=> o_sfr_addr[2:0] == SFR_BIT_LOW_NIBBLE && !o_bad_bit)
        else $error("sfr bit not on a bit-addressable register");
    AST_CODE_FLASH: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) i_req && i_mode == MAD_CODE
        && i_addr <= flash_last |=> o_target == MAD_T_FLASH)
        else $error("code read not from flash");
    AST_CODE_RESERVED: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) i_req && code_reserved
        |=> o_reserved && o_target == MAD_T_NONE)
        else $error("reserved code address not flagged");
    AST_FLASH_WR: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) i_req && xdata_flash
        |=> o_target == MAD_T_FLASH_WR)
        else $error("redirected xdata write not sent to flash");
    AST_XDATA16: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) i_req && i_mode == MAD_XDATA16
        |=> o_onchip_external_ram_addr == $past(data_pointer_16_now))
        else $error("16-bit xdata address wrong");
    AST_XDATA8: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) i_req && i_mode == MAD_XDATA8
        |=> o_onchip_external_ram_addr == $past(x8_now))
        else $error("8-bit xdata address wrong");
    AST_ONCHIP_EXTERNAL_RAM_DEFAULT: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) i_req && is_xdata && !i_flash_wr_redirect
        |=> o_target == MAD_T_ONCHIP_EXTERNAL_RAM)
        else $error("xdata not routed to external ram");
    COV_PUSH: cover property (@(posedge i_sys_clk) push ##1 push);
    COV_SFR: cover property (@(posedge i_sys_clk) o_target == MAD_T_SFR);
    COV_FLASH_WR: cover property (@(posedge i_sys_clk)
        o_target == MAD_T_FLASH_WR);
    COV_BIT_SFR: cover property (@(posedge i_sys_clk)
        o_bit_access && o_target == MAD_T_SFR);
    COV_RESERVED: cover property (@(posedge i_sys_clk) o_reserved);
endmodule

//--- mad_pkg.sv
package mad_pkg;
    // sfr addresses
    localparam logic [7:0] SFR_STACK_POINTER = 8'h81;
    localparam logic [7:0] SFR_DATA_POINTER_LOW = 8'h82;
    localparam logic [7:0] SFR_DATA_POINTER_HIGH = 8'h83;
    localparam logic [7:0] SFR_PROGRAM_STATUS_WORD = 8'hD0;
    localparam logic [7:0] SFR_ONCHIP_EXTERNAL_RAM_UPPER_ADDRESS_PAGE = 8'hAA;
    // reset values
    localparam logic [7:0] STACK_POINTER_RST = 8'h07;
    localparam logic [7:0] ONCHIP_EXTERNAL_RAM_PAGE_RST = 8'h00;
    localparam logic [7:0] DATA_POINTER_16_BYTE_RST = 8'h00;
    localparam logic [7:0] PSW_RST = 8'h00;
    // fields and boundaries
    localparam int BANK_SELECT_LOW_POS = 3;
    localparam int BANK_SELECT_HIGH_POS = 4;
    localparam logic [7:0] LOWER_RAM_TOP = 8'h7F;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [2:0] SFR_BIT_LOW_NIBBLE = 3'h0;
    localparam logic [15:0] FLASH_LAST_16K = 16'h3BFF;
    localparam logic [15:0] FLASH_LAST_8K = 16'h1FFF;
    localparam int DATA_RAM_BYTES = 768;
    localparam int IRAM_BYTES = 256;
    localparam int ONCHIP_EXTERNAL_RAM_BYTES = 512;
    // access kinds presented by the core
    typedef enum logic [2:0] {
        MAD_DIRECT,
        MAD_INDIRECT,
        MAD_BIT,
        MAD_CODE,
        MAD_XDATA16,
        MAD_XDATA8,
        MAD_PUSH,
        MAD_POP
    } mad_mode_e;
    // selected targets
    typedef enum logic [2:0] {
        MAD_T_NONE,
        MAD_T_IRAM,
        MAD_T_SFR,
        MAD_T_FLASH,
        MAD_T_ONCHIP_EXTERNAL_RAM,
        MAD_T_FLASH_WR
    } mad_target_e;
endpackage

//--- test_cpu_memory_address_decoder.sv
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        samples_checked++; \
        if ((a) !== (b)) \
        begin \
            n_mismatch++; \
            $display("ERROR %0t got %h exp %h", $time, (a), (b)); \
        end \
    end
module test_cpu_memory_address_decoder
    import mad_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic req, wr, ptr, redir, o_valid, o_bit_access, o_write, o_reserved;
    logic o_bad_bit;
    mad_mode_e mode;
    mad_target_e o_target;
    logic [15:0] addr, o_code_addr, o_data_pointer_16;
    logic [7:0] wd, o_iram_addr, o_sfr_addr, o_wdata, o_stack_pointer;
    logic [7:0] o_onchip_external_ram_upper_address_page;
    logic [8:0] o_onchip_external_ram_addr;
    logic [2:0] o_bit_pos;
    logic [1:0] o_active_bank;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [7:0] bit_in [4] = '{8'h13, 8'h7F, 8'h00, 8'h83};
    logic [7:0] byte_exp [4] = '{8'h22, 8'h2F, 8'h20, 8'h80};
    logic [2:0] pos_exp [4] = '{3'h3, 3'h7, 3'h0, 3'h3};
    always #4 i_sys_clk = ~i_sys_clk;
    mad_core_model u_mad_core_model (.i_sys_clk(i_sys_clk), .o_req(req),
        .o_mode(mode), .o_write(wr), .o_addr(addr), .o_ptr_sel(ptr),
        .o_wdata(wd), .o_redirect(redir));
    mad_decoder u_mad_decoder (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_req(req), .i_mode(mode), .i_write(wr), .i_addr(addr),
        .i_ptr_sel(ptr), .i_wdata(wd), .i_flash_wr_redirect(redir),
        .o_valid(o_valid), .o_target(o_target), .o_iram_addr(o_iram_addr),
        .o_onchip_external_ram_addr(o_onchip_external_ram_addr), .o_code_addr(o_code_addr),
        .o_sfr_addr(o_sfr_addr), .o_bit_access(o_bit_access),
        .o_bit_pos(o_bit_pos), .o_write(o_write), .o_wdata(o_wdata),
        .o_reserved(o_reserved), .o_bad_bit(o_bad_bit),
        .o_stack_pointer(o_stack_pointer),
        .o_data_pointer_16(o_data_pointer_16),
        .o_onchip_external_ram_upper_address_page(o_onchip_external_ram_upper_address_page),
        .o_active_bank(o_active_bank));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic acc(input mad_mode_e m, input logic w,
        input logic [15:0] a, input logic p, input logic [7:0] d,
        input logic r);
        int n = 0;
        u_mad_core_model.issue(m, w, a, p, d, r, n_mismatch % 2);
        #1;
        while (o_valid !== 1'b1 && n < 4)
        begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        if (o_valid !== 1'b1)
        begin
            n_mismatch++;
            close_out();
        end
    endtask
    task automatic tick();
        @(posedge i_sys_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        n_mismatch++;
        close_out();
    end
    initial
    begin
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        #1;
        `CHK(o_stack_pointer, 8'h07)
        `CHK(o_data_pointer_16, 16'h0000)
        acc(MAD_PUSH, 1'b1, 16'h0000, 1'b0, 8'hA5, 1'b0);
        `CHK(o_target, MAD_T_IRAM)
        `CHK(o_iram_addr, 8'h08)
        `CHK(o_write, 1'b1)
        `CHK(o_wdata, 8'hA5)
        tick();
        `CHK(o_stack_pointer, 8'h08)
        acc(MAD_POP, 1'b0, 16'h0000, 1'b0, 8'h00, 1'b0);
        `CHK(o_iram_addr, 8'h08)
        tick();
        `CHK(o_stack_pointer, 8'h07)
        $display("test stack done");
        acc(MAD_DIRECT, 1'b1, 16'h00D0, 1'b0, 8'h18, 1'b0);
        tick();
        `CHK(o_active_bank, 2'h3)
        acc(MAD_DIRECT, 1'b1, 16'h0018, 1'b0, 8'h90, 1'b0);
        acc(MAD_DIRECT, 1'b1, 16'h0019, 1'b0, 8'h55, 1'b0);
        acc(MAD_INDIRECT, 1'b0, 16'h0000, 1'b0, 8'h00, 1'b0);
        `CHK(o_target, MAD_T_IRAM)
        `CHK(o_iram_addr, 8'h90)
        acc(MAD_INDIRECT, 1'b0, 16'h0000, 1'b1, 8'h00, 1'b0);
        `CHK(o_iram_addr, 8'h55)
        acc(MAD_DIRECT, 1'b0, 16'h0090, 1'b0, 8'h00, 1'b0);
        `CHK(o_target, MAD_T_SFR)
        `CHK(o_sfr_addr, 8'h90)
        `CHK(o_bit_access, 1'b0)
        acc(MAD_DIRECT, 1'b0, 16'h007F, 1'b0, 8'h00, 1'b0);
        `CHK(o_target, MAD_T_IRAM)
        `CHK(o_iram_addr, 8'h7F)
        $display("test banks done");
        for (int i = 0; i < 4; i++)
        begin
            acc(MAD_BIT, 1'b0, {8'h00, bit_in[i]}, 1'b0, 8'h00, 1'b0);
            `CHK(o_bit_access, 1'b1)
            `CHK(o_bad_bit, 1'b0)
            `CHK(o_bit_pos, pos_exp[i])
            if (i < 3)
                `CHK(o_iram_addr, byte_exp[i])
            else
                `CHK(o_sfr_addr, byte_exp[i])
        end
        $display("test bits done");
        acc(MAD_CODE, 1'b0, 16'h3BFF, 1'b0, 8'h00, 1'b0);
        `CHK(o_target, MAD_T_FLASH)
        `CHK(o_code_addr, 16'h3BFF)
        `CHK(o_reserved, 1'b0)
        acc(MAD_CODE, 1'b0, 16'h3C00, 1'b0, 8'h00, 1'b0);
        `CHK(o_target, MAD_T_NONE)
        `CHK(o_reserved, 1'b1)
        $display("test code done");
        acc(MAD_XDATA16, 1'b1, 16'h0000, 1'b0, 8'h3C, 1'b0);
        `CHK(o_target, MAD_T_ONCHIP_EXTERNAL_RAM)
        `CHK(o_onchip_external_ram_addr, 9'h000)
        acc(MAD_DIRECT, 1'b1, 16'h0083, 1'b0, 8'h12, 1'b0);
        acc(MAD_DIRECT, 1'b1, 16'h0082, 1'b0, 8'h34, 1'b0);
        acc(MAD_DIRECT, 1'b1, 16'h00AA, 1'b0, 8'h01, 1'b0);
        tick();
        `CHK(o_data_pointer_16, 16'h1234)
        `CHK(o_onchip_external_ram_upper_address_page, 8'h01)
        acc(MAD_XDATA16, 1'b0, 16'h0000, 1'b0, 8'h00, 1'b0);
        `CHK(o_target, MAD_T_ONCHIP_EXTERNAL_RAM)
        `CHK(o_onchip_external_ram_addr, 9'h034)
        acc(MAD_XDATA16, 1'b1, 16'h0000, 1'b0, 8'h77, 1'b1);
        `CHK(o_target, MAD_T_FLASH_WR)
        acc(MAD_XDATA8, 1'b0, 16'h0000, 1'b1, 8'h00, 1'b0);
        `CHK(o_target, MAD_T_ONCHIP_EXTERNAL_RAM)
        `CHK(o_onchip_external_ram_addr, 9'h155)
        acc(MAD_XDATA8, 1'b0, 16'h0000, 1'b0, 8'h00, 1'b0);
        `CHK(o_onchip_external_ram_addr, 9'h190)
        $display("test xdata done");
        acc(MAD_DIRECT, 1'b1, 16'h0081, 1'b0, 8'hFF, 1'b0);
        acc(MAD_PUSH, 1'b1, 16'h0000, 1'b0, 8'h5A, 1'b0);
        `CHK(o_iram_addr, 8'h00)
        tick();
        `CHK(o_stack_pointer, 8'h00)
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        @(posedge i_sys_clk);
        i_rst <= 1'b0;
        #1;
        `CHK(o_stack_pointer, 8'h07)
        `CHK(o_active_bank, 2'h0)
        `CHK(o_data_pointer_16, 16'h0000)
        $display("test wrap and reset done");
        close_out();
    end
endmodule
